// ==== rtl/frs_pkg.sv ====
// Purpose: constants for the refresh rate mode select block
// Assumes: 200 MHz clk_sys, 8Gb density tRFC figures selected
// Notes: command pins arrive from outside the clock domain
// Summary of operation
// - refresh cycle and interval come from a mode register write, fixed or dynamic.
// - field bits 8:6 decode 000/001/010 fixed, 101/110 dynamic, rest reserved.
// - in dynamic modes bg0 is sampled with each refresh to pick granularity.
// - bg0 low gives normal rate; high gives double or quad per mode.
// - refresh is cs low, act high, ras low, cas low, we high.
// - after reset the mode is fixed 1x with base interval and normal cycle.
// - cycle time 350/260/160 ns for normal/double/quad; base interval 7.8 us.
// - a new rate applies from its change; each refresh uses its own timing.
package frs_pkg;
	localparam logic [2:0] MODE_FIX1 = 3'h0;
	localparam logic [2:0] MODE_FIX2 = 3'h1;
	localparam logic [2:0] MODE_FIX4 = 3'h2;
	localparam logic [2:0] MODE_DYN12 = 3'h5;
	localparam logic [2:0] MODE_DYN14 = 3'h6;
	localparam logic [2:0] MR3_SEL = 3'h3;
	localparam int FIELD_LSB = 6;
	localparam int CLK_PS = 5000;
	localparam int TRFC1_NS = 350;
	localparam int TRFC2_NS = 260;
	localparam int TRFC4_NS = 160;
	localparam int TREFI_BASE_NS = 7800;
	localparam logic [7:0] TRFC1_CYC = 8'((TRFC1_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] TRFC2_CYC = 8'((TRFC2_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] TRFC4_CYC = 8'((TRFC4_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [11:0] TREFI1_CYC = 12'((TREFI_BASE_NS * 1000) / CLK_PS);
	localparam logic [11:0] TREFI2_CYC = 12'((TREFI_BASE_NS * 1000) / (2 * CLK_PS));
	localparam logic [11:0] TREFI4_CYC = 12'((TREFI_BASE_NS * 1000) / (4 * CLK_PS));
	typedef enum logic [2:0] {
		GRAN_1X = 3'b001,
		GRAN_2X = 3'b010,
		GRAN_4X = 3'b100
	} frs_gran_e;
endpackage

// ==== rtl/frs_sync3.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: din is asynchronous to clk_sys
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
module frs_sync3 #(
	parameter int W = 1
) (
	clk_sys,
	arst_n,
	din,
	dout
);
	input wire logic clk_sys;
	input wire logic arst_n;
	input wire logic [W-1:0] din;
	output logic [W-1:0] dout;
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} frs_sync_s;
	frs_sync_s st_reg;
	frs_sync_s st_next;
	always_comb begin
		st_next = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// change counts once stage two and three agree
		if (st_reg.s2 == st_reg.s3) begin
			st_next.q = st_reg.s3;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign dout = st_reg.q;
endmodule

// ==== rtl/frs_refresh_mode.sv ====
// Purpose: decode refresh rate mode and classify refresh commands
// Assumes: command pins sampled on rising ck edges found by clk_sys
// Notes: pins pass the 3-stage filter, so latency is about 4 cycles
`timescale 1ns/1ps
module frs_refresh_mode
	import frs_pkg::*;
(
	clk_sys,
	arst_n,
	ck,
	cs_n,
	act_n,
	ras_n,
	cas_n,
	we_n,
	bg0,
	ba,
	mr_op,
	refresh_mode,
	dynamic_rate_select,
	mode_reserved_err,
	ref_pulse,
	ref_gran,
	ref_illegal,
	ref_busy,
	trfc_cyc,
	trefi_cyc
);
	input wire logic clk_sys;
	input wire logic arst_n;
	input wire logic ck;
	input wire logic cs_n;
	input wire logic act_n;
	input wire logic ras_n;
	input wire logic cas_n;
	input wire logic we_n;
	input wire logic bg0;
	input wire logic [2:0] ba;
	input wire logic [2:0] mr_op;
	output logic [2:0] refresh_mode;
	output logic dynamic_rate_select;
	output logic mode_reserved_err;
	output logic ref_pulse;
	output frs_gran_e ref_gran;
	output logic ref_illegal;
	output logic ref_busy;
	output logic [7:0] trfc_cyc;
	output logic [11:0] trefi_cyc;

	typedef struct packed {
		logic ck_d;
		logic [2:0] mode;
		logic dyn;
		logic err;
		logic pulse;
		frs_gran_e gran;
		logic illegal;
		logic busy;
		logic [7:0] rfc_cnt;
		logic [7:0] rfc;
		logic [11:0] refi;
	} frs_state_s;

	frs_state_s st_reg;
	frs_state_s st_next;
	logic [11:0] pins_s;
	logic ck_s;

	frs_sync3 #(.W(13)) u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.din({ck, cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, mr_op}),
		.dout({ck_s, pins_s})
	);

	function automatic logic is_reserved(input logic [2:0] m);
		return !(m == MODE_FIX1 || m == MODE_FIX2 || m == MODE_FIX4 ||
			m == MODE_DYN12 || m == MODE_DYN14);
	endfunction

	function automatic logic [7:0] rfc_of(input frs_gran_e g);
		case (g)
			GRAN_2X: return TRFC2_CYC;
			GRAN_4X: return TRFC4_CYC;
			default: return TRFC1_CYC;
		endcase
	endfunction

	function automatic logic [11:0] refi_of(input frs_gran_e g);
		case (g)
			GRAN_2X: return TREFI2_CYC;
			GRAN_4X: return TREFI4_CYC;
			default: return TREFI1_CYC;
		endcase
	endfunction

	logic p_cs_n, p_act_n, p_ras_n, p_cas_n, p_we_n, p_bg0;
	logic [2:0] p_ba;
	logic [2:0] p_op;
	logic ck_rise;
	logic is_ref;
	logic is_mrs3;
	frs_gran_e g;
	always_comb begin
		{p_cs_n, p_act_n, p_ras_n, p_cas_n, p_we_n, p_bg0, p_ba, p_op} = pins_s;
		ck_rise = ck_s && !st_reg.ck_d;
		st_next = st_reg;
		st_next.ck_d = ck_s;
		st_next.pulse = 1'b0;
		g = GRAN_1X;
		// refresh decode
		is_ref = ck_rise && !p_cs_n && p_act_n && !p_ras_n && !p_cas_n && p_we_n;
		is_mrs3 = ck_rise && !p_cs_n && p_act_n && !p_ras_n && !p_cas_n && !p_we_n &&
			p_ba == MR3_SEL;
		if (st_reg.busy) begin
			// a refresh meanwhile restarts the count and is flagged illegal
			if (st_reg.rfc_cnt <= 8'h01) begin
				st_next.busy = 1'b0;
				st_next.rfc_cnt = 8'h00;
			end else begin
				st_next.rfc_cnt = st_reg.rfc_cnt - 8'h01;
			end
		end
		if (is_mrs3) begin
			st_next.mode = p_op;
			st_next.err = is_reserved(p_op);
			st_next.dyn = (p_op == MODE_DYN12) || (p_op == MODE_DYN14);
			// new interval applies from the change
			case (p_op)
				MODE_FIX2: g = GRAN_2X;
				MODE_FIX4: g = GRAN_4X;
				default: g = GRAN_1X;
			endcase
			st_next.gran = g;
			st_next.rfc = rfc_of(g);
			st_next.refi = refi_of(g);
		end else if (is_ref) begin
			case (st_reg.mode)
				MODE_FIX2: g = GRAN_2X;
				MODE_FIX4: g = GRAN_4X;
				MODE_DYN12: g = p_bg0 ? GRAN_2X : GRAN_1X;
				MODE_DYN14: g = p_bg0 ? GRAN_4X : GRAN_1X;
				default: g = GRAN_1X;
			endcase
			// reserved mode treated as 1x; flagged via err
			st_next.illegal = is_reserved(st_reg.mode) || st_reg.busy;
			st_next.pulse = 1'b1;
			st_next.gran = g;
			st_next.rfc = rfc_of(g);
			st_next.refi = refi_of(g);
			st_next.busy = 1'b1;
			st_next.rfc_cnt = rfc_of(g);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg.ck_d <= 1'b0;
			st_reg.mode <= MODE_FIX1;
			st_reg.err <= 1'b0;
			st_reg.dyn <= 1'b0;
			st_reg.pulse <= 1'b0;
			st_reg.gran <= GRAN_1X;
			st_reg.illegal <= 1'b0;
			st_reg.busy <= 1'b0;
			st_reg.rfc_cnt <= 8'h00;
			st_reg.rfc <= TRFC1_CYC;
			st_reg.refi <= TREFI1_CYC;
		end else begin
			st_reg <= st_next;
		end
	end

	assign refresh_mode = st_reg.mode;
	// own flop, so the flag carries no decode glitch
	assign dynamic_rate_select = st_reg.dyn;
	assign mode_reserved_err = st_reg.err;
	assign ref_pulse = st_reg.pulse;
	assign ref_gran = st_reg.gran;
	assign ref_illegal = st_reg.illegal;
	assign ref_busy = st_reg.busy;
	assign trfc_cyc = st_reg.rfc;
	assign trefi_cyc = st_reg.refi;

	chk_reset_mode: assert property (@(posedge clk_sys)
		$rose(arst_n) |-> st_reg.mode == MODE_FIX1)
		else $error("mode not fixed 1x after reset");
	chk_mode_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!$past(is_mrs3) |-> $stable(st_reg.mode))
		else $error("mode changed without write");
	chk_fixed_gran: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(is_ref && st_reg.mode == MODE_FIX2) |=> ref_gran == GRAN_2X && ref_pulse)
		else $error("fixed 2x gave wrong granularity");
	chk_dyn_bg0: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(is_ref && st_reg.mode == MODE_DYN14) |=>
		ref_gran == ($past(p_bg0) ? GRAN_4X : GRAN_1X))
		else $error("dynamic bg0 select wrong");
	chk_rfc_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(ref_pulse && ref_gran == GRAN_1X) |-> ref_busy [*8])
		else $error("refresh cycle ended early");
	chk_reserved_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(is_mrs3 && is_reserved(p_op)) |=> mode_reserved_err)
		else $error("reserved code not flagged");
	chk_refi_2x: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ref_gran == GRAN_2X |-> trefi_cyc == TREFI2_CYC && trfc_cyc == TRFC2_CYC)
		else $error("2x timing values wrong");
	chk_refi_4x: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ref_gran == GRAN_4X |-> trefi_cyc == TREFI4_CYC && trfc_cyc == TRFC4_CYC)
		else $error("4x timing values wrong");
	// a refresh inside the window restarts the count, so it also ends the wait
	chk_busy_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ref_pulse |-> ##[1:70] (!ref_busy || ref_pulse))
		else $error("busy never ended");
	chk_busy_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(is_ref && st_reg.busy) |=> ref_illegal)
		else $error("refresh during busy not flagged");
	chk_dyn_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
		dynamic_rate_select |-> refresh_mode == MODE_DYN12 || refresh_mode == MODE_DYN14)
		else $error("dynamic flag without dynamic mode");
	cov_dyn12: cover property (@(posedge clk_sys) ref_pulse && st_reg.mode == MODE_DYN12);
	cov_quad: cover property (@(posedge clk_sys) ref_pulse && ref_gran == GRAN_4X);
	cov_illegal: cover property (@(posedge clk_sys) ref_pulse && ref_illegal);
	cov_dyn14_1x: cover property (@(posedge clk_sys)
		ref_pulse && st_reg.mode == MODE_DYN14 && ref_gran == GRAN_1X);
	cov_reserved: cover property (@(posedge clk_sys) ref_pulse && mode_reserved_err);
endmodule

// ==== verif/frs_ctl_model.sv ====
// Purpose: controller model driving the command pins
// Assumes: ck runs free at 64 ns, as a dram clock does
// Notes: pins change after ck fall, held across the following rise
`timescale 1ns/1ps
module frs_ctl_model (
	input wire logic clk_sys,
	output logic ck,
	output logic cs_n,
	output logic act_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic bg0,
	output logic [2:0] ba,
	output logic [2:0] mr_op
);
	initial begin
		ck = 1'b0;
		{cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, mr_op} = '1;
	end
	always #32 ck = ~ck;
	// one command over one ck rise, then deselect
	task automatic cmd(input logic [4:0] c, input logic b, input logic [2:0] a,
		input logic [2:0] o);
		@(negedge ck);
		@(negedge clk_sys);
		{cs_n, act_n, ras_n, cas_n, we_n} = c;
		bg0 = b;
		// register 4 is never written, so temperature-controlled refresh stays off
		ba = a;
		mr_op = o;
		@(negedge ck);
		@(negedge clk_sys);
		cs_n = 1'b1;
		// deselected pins carry no meaning, so flip them rather than hold
		{act_n, ras_n, cas_n, we_n, bg0, ba, mr_op} = ~{act_n, ras_n, cas_n, we_n, bg0, ba, mr_op};
	endtask
endmodule

// ==== verif/tb_dram_refresh_rate_mode_select.sv ====
// Purpose: self-checking bench for the refresh mode block
// Assumes: 8Gb cycle figures from the package
// Notes: pair counts of double and quad refreshes are not judged
`timescale 1ns/1ps
`define CHK(s, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %0h got %0h", s, e, g); end end
module tb_dram_refresh_rate_mode_select;
	import frs_pkg::*;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic ck, cs_n, act_n, ras_n, cas_n, we_n, bg0, dyn, err, ref_pulse, ref_illegal, ref_busy;
	logic [2:0] ba, mr_op, refresh_mode;
	frs_gran_e ref_gran, g_seen;
	logic ill_seen;
	logic [7:0] trfc_cyc;
	logic [11:0] trefi_cyc;
	int fails = 0;
	int cmp_count = 0;
	int npulse = 0;
	int busy_len = 0;
	always #2.5 clk_sys = ~clk_sys;
	frs_ctl_model i_ctl(.clk_sys(clk_sys), .ck(ck), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bg0(bg0), .ba(ba), .mr_op(mr_op));
	frs_refresh_mode i_dut(.clk_sys(clk_sys), .arst_n(arst_n), .ck(ck), .cs_n(cs_n),
		.act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg0(bg0), .ba(ba),
		.mr_op(mr_op), .refresh_mode(refresh_mode), .dynamic_rate_select(dyn),
		.mode_reserved_err(err), .ref_pulse(ref_pulse), .ref_gran(ref_gran),
		.ref_illegal(ref_illegal), .ref_busy(ref_busy), .trfc_cyc(trfc_cyc),
		.trefi_cyc(trefi_cyc));
	always @(negedge clk_sys) begin
		if (ref_pulse === 1'b1) begin
			npulse++;
			g_seen = ref_gran;
			ill_seen = ref_illegal;
			busy_len = 0;
		end
		if (ref_busy === 1'b1)
			busy_len++;
	end
	task automatic settle();
		repeat (8) @(negedge clk_sys);
		for (int i = 0; i < 200 && ref_busy !== 1'b0; i++)
			@(negedge clk_sys);
	endtask
	task automatic mrs(input logic [2:0] o);
		i_ctl.cmd(5'h08, 1'b0, 3'h3, o);
		settle();
	endtask
	// refresh that must be accepted with granularity eg
	task automatic refchk(input logic b, input frs_gran_e eg);
		int n;
		logic [7:0] erfc;
		logic [11:0] erefi;
		n = npulse;
		erfc = eg == GRAN_2X ? TRFC2_CYC : eg == GRAN_4X ? TRFC4_CYC : TRFC1_CYC;
		erefi = eg == GRAN_2X ? TREFI2_CYC : eg == GRAN_4X ? TREFI4_CYC : TREFI1_CYC;
		i_ctl.cmd(5'h09, b, 3'h0, 3'h0);
		settle();
		`CHK("pulses", n + 1, npulse)
		`CHK("gran", eg, g_seen)
		`CHK("illegal", 1'b0, ill_seen)
		`CHK("busy", erfc, 8'(busy_len))
		`CHK("trfc", erfc, trfc_cyc)
		`CHK("trefi", erefi, trefi_cyc)
	endtask
	task automatic t_modes();
		for (int c = 0; c < 8; c++) begin
			mrs(3'(c));
			`CHK("mode", 3'(c), refresh_mode)
			`CHK("dyn", 1'(c == 5 || c == 6), dyn)
			`CHK("err", 1'(c == 3 || c == 4 || c == 7), err)
			`CHK("trfc", c == 1 ? TRFC2_CYC : c == 2 ? TRFC4_CYC : TRFC1_CYC, trfc_cyc)
			`CHK("trefi", c == 1 ? TREFI2_CYC : c == 2 ? TREFI4_CYC : TREFI1_CYC, trefi_cyc)
		end
		i_ctl.cmd(5'h09, 1'b0, 3'h0, 3'h0);
		settle();
		`CHK("illegal", 1'b1, ill_seen)
	endtask
	task automatic t_other();
		int n;
		mrs(3'h0);
		i_ctl.cmd(5'h08, 1'b0, 3'h2, 3'h1);
		settle();
		`CHK("mode", 3'h0, refresh_mode)
		n = npulse;
		i_ctl.cmd(5'h19, 1'b0, 3'h0, 3'h0);
		i_ctl.cmd(5'h01, 1'b0, 3'h0, 3'h0);
		settle();
		`CHK("pulses", n, npulse)
		i_ctl.cmd(5'h09, 1'b0, 3'h0, 3'h0);
		i_ctl.cmd(5'h09, 1'b0, 3'h0, 3'h0);
		settle();
		`CHK("illegal", 1'b1, ill_seen)
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#60000;
		fails++;
		close_out();
	end
	initial begin
		repeat (2) @(negedge clk_sys);
		arst_n = 1'b1;
		settle();
		`CHK("mode", 3'h0, refresh_mode)
		`CHK("gran", GRAN_1X, ref_gran)
		`CHK("trfc", TRFC1_CYC, trfc_cyc)
		t_modes();
		mrs(3'h5);
		refchk(1'b0, GRAN_1X);
		refchk(1'b1, GRAN_2X);
		refchk(1'b1, GRAN_2X);
		`CHK("mode", 3'h5, refresh_mode)
		mrs(3'h6);
		for (int i = 0; i < 4; i++)
			refchk(1'b1, GRAN_4X);
		refchk(1'b0, GRAN_1X);
		mrs(3'h1);
		refchk(1'b0, GRAN_2X);
		refchk(1'b1, GRAN_2X);
		mrs(3'h2);
		for (int i = 0; i < 4; i++)
			refchk(1'(i), GRAN_4X);
		t_other();
		close_out();
	end
endmodule
